/* rtl/rpsb_bank.sv */
// remappable pin select bank with apb register access
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "rpsb_defs.svh"
module rpsb_bank (
    // clock and reset
    input  wire logic                      CLOCK_IN,
    input  wire logic                      RESET_IN,
    // apb slave
    input  wire logic                      PSEL_IN,
    input  wire logic                      PENABLE_IN,
    input  wire logic                      PWRITE_IN,
    input  wire logic [11:0]               PADDR_IN,
    input  wire logic [31:0]               PWDATA_IN,
    output logic [31:0]                    PRDATA_OUT,
    output logic                           PREADY_OUT,
    output logic                           PSLVERR_OUT,
    // remappable pins
    input  wire logic [15:0]               REMAPPABLE_PIN_IN,
    output logic [15:0]                    REMAPPABLE_PIN_OUT,
    output logic [15:0]                    REMAPPABLE_PIN_OE_OUT,
    // port latch fallback and peripheral outputs
    input  wire logic [15:0]               PORT_DATA_IN,
    input  wire logic [15:0]               PORT_OE_IN,
    input  wire logic [31:0]               PERIPH_FUNC_IN,
    input  wire logic [31:0]               PERIPH_FUNC_OE_IN,
    // routed peripheral inputs
    output rpsb_pkg::rpsb_periph_in_t      PERIPH_IN_OUT
);
    rpsb_pkg::rpsb_state_t state;
    rpsb_pkg::rpsb_sel_t   uart_cts_pin_sel;
    rpsb_pkg::rpsb_sel_t   uart_rx_pin_sel;
    rpsb_pkg::rpsb_sel_t   spi_clk_pin_sel;
    rpsb_pkg::rpsb_sel_t   spi_din_pin_sel;
    rpsb_pkg::rpsb_sel_t   spi_slave_sel_pin_sel;
    rpsb_pkg::rpsb_sel_t   compare_fault_a_pin_sel;
    rpsb_pkg::rpsb_sel_t   pin_out_func [16];
    logic                  io_map_lock;
    logic [15:0]           analog_mode;
    logic [15:0]           pin_meta;
    logic [15:0]           pin_sync;
    logic [15:0]           pin_digital;
    logic                  wr_en;
    logic                  rd_en;
    logic                  cfg_wr;
    logic [31:0]           next_rdata;
    logic                  addr_ok;

    // decode shared by the read mux and the write path
    function automatic logic is_out_pair(input logic [11:0] a);
        is_out_pair = (a >= `RPSB_OFF_OUT_PAIR0) &&
                      (a < `RPSB_OFF_CTRL) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [2:0] pair_index(input logic [11:0] a);
        logic [11:0] d;
        d = a - `RPSB_OFF_OUT_PAIR0;
        pair_index = d[4:2];
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `RPSB_OFF_UART_IN) ||
                    (a == `RPSB_OFF_SPI_CD_IN) ||
                    (a == `RPSB_OFF_SPI_SS_IN) ||
                    (a == `RPSB_OFF_FAULT_IN) ||
                    (a == `RPSB_OFF_CTRL) || is_out_pair(a);
    endfunction

    // one-cycle wait state keeps read data registered
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            state <= rpsb_pkg::RPSB_IDLE;
        end else begin
            case (state)
                rpsb_pkg::RPSB_IDLE: begin
                    if (PSEL_IN && PENABLE_IN) begin
                        state <= rpsb_pkg::RPSB_ACCESS;
                    end
                end
                rpsb_pkg::RPSB_ACCESS: begin
                    state <= rpsb_pkg::RPSB_IDLE;
                end
                default: begin
                    state <= rpsb_pkg::RPSB_IDLE;
                end
            endcase
        end
    end

    assign PREADY_OUT  = (state == rpsb_pkg::RPSB_ACCESS);
    assign addr_ok     = is_mapped(PADDR_IN);
    assign PSLVERR_OUT = PREADY_OUT && !addr_ok;
    assign wr_en  = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN &&
                    addr_ok;
    assign rd_en  = PSEL_IN && PENABLE_IN && !PWRITE_IN &&
                    (state == rpsb_pkg::RPSB_IDLE);
    assign cfg_wr = wr_en && !io_map_lock;

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            uart_cts_pin_sel        <= 5'h00;
            uart_rx_pin_sel         <= 5'h00;
            spi_clk_pin_sel         <= 5'h00;
            spi_din_pin_sel         <= 5'h00;
            spi_slave_sel_pin_sel   <= 5'h00;
            compare_fault_a_pin_sel <= 5'h00;
        end else if (cfg_wr) begin
            case (PADDR_IN)
                `RPSB_OFF_UART_IN: begin
                    uart_cts_pin_sel <= PWDATA_IN[`RPSB_HI_LSB +: 5];
                    uart_rx_pin_sel  <= PWDATA_IN[`RPSB_LO_LSB +: 5];
                end
                `RPSB_OFF_SPI_CD_IN: begin
                    spi_clk_pin_sel <= PWDATA_IN[`RPSB_HI_LSB +: 5];
                    spi_din_pin_sel <= PWDATA_IN[`RPSB_LO_LSB +: 5];
                end
                `RPSB_OFF_SPI_SS_IN: begin
                    spi_slave_sel_pin_sel <= PWDATA_IN[`RPSB_LO_LSB +: 5];
                end
                `RPSB_OFF_FAULT_IN: begin
                    compare_fault_a_pin_sel <=
                        PWDATA_IN[`RPSB_LO_LSB +: 5];
                end
                default: begin
                end
            endcase
        end
    end

    // output function fields, pairs of pins per word
    genvar g;
    generate
        for (g = 0; g < `RPSB_NUM_PAIRS; g++) begin : g_pair
            always_ff @(posedge CLOCK_IN) begin
                if (RESET_IN) begin
                    pin_out_func[2*g]   <= `RPSB_FUNC_NULL;
                    pin_out_func[2*g+1] <= `RPSB_FUNC_NULL;
                end else if (cfg_wr && is_out_pair(PADDR_IN) &&
                             pair_index(PADDR_IN) == 3'(g)) begin
                    pin_out_func[2*g]   <= PWDATA_IN[`RPSB_LO_LSB +: 5];
                    pin_out_func[2*g+1] <= PWDATA_IN[`RPSB_HI_LSB +: 5];
                end
            end
        end
    endgenerate

    // lock and analog control stay writable so software can unlock
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            io_map_lock <= 1'b0;
            analog_mode <= 16'h0000;
        end else if (wr_en && PADDR_IN == `RPSB_OFF_CTRL) begin
            io_map_lock <= PWDATA_IN[`RPSB_LOCK_BIT];
            analog_mode <= PWDATA_IN[`RPSB_ANALOG_LSB +: 16];
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (PADDR_IN)
            `RPSB_OFF_UART_IN:
                next_rdata = {19'h0, uart_cts_pin_sel, 3'h0,
                              uart_rx_pin_sel};
            `RPSB_OFF_SPI_CD_IN:
                next_rdata = {19'h0, spi_clk_pin_sel, 3'h0,
                              spi_din_pin_sel};
            `RPSB_OFF_SPI_SS_IN:
                next_rdata = {27'h0, spi_slave_sel_pin_sel};
            `RPSB_OFF_FAULT_IN:
                next_rdata = {27'h0, compare_fault_a_pin_sel};
            `RPSB_OFF_CTRL:
                next_rdata = {analog_mode, 15'h0, io_map_lock};
            default: begin
                if (is_out_pair(PADDR_IN)) begin
                    next_rdata = {19'h0,
                        pin_out_func[{pair_index(PADDR_IN), 1'b1}], 3'h0,
                        pin_out_func[{pair_index(PADDR_IN), 1'b0}]};
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            PRDATA_OUT <= 32'h0000_0000;
        end else if (rd_en) begin
            PRDATA_OUT <= next_rdata;
        end
    end

    // pins come from outside the clock domain
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            pin_meta <= 16'h0000;
            pin_sync <= 16'h0000;
        end else begin
            pin_meta <= REMAPPABLE_PIN_IN;
            pin_sync <= pin_meta;
        end
    end

    // analog pins give the peripherals no digital level
    assign pin_digital = pin_sync & ~analog_mode;

    // routing follows the registers with no extra stage
    rpsb_input_mux u_rx (
        .SEL_IN     (uart_rx_pin_sel),
        .PINS_IN    (pin_digital),
        .ROUTED_OUT (PERIPH_IN_OUT.uart_receive_in)
    );
    rpsb_input_mux u_cts (
        .SEL_IN     (uart_cts_pin_sel),
        .PINS_IN    (pin_digital),
        .ROUTED_OUT (PERIPH_IN_OUT.uart_clear_to_send)
    );
    rpsb_input_mux u_sck (
        .SEL_IN     (spi_clk_pin_sel),
        .PINS_IN    (pin_digital),
        .ROUTED_OUT (PERIPH_IN_OUT.spi_clock_in)
    );
    rpsb_input_mux u_sdi (
        .SEL_IN     (spi_din_pin_sel),
        .PINS_IN    (pin_digital),
        .ROUTED_OUT (PERIPH_IN_OUT.spi_data_in)
    );
    rpsb_input_mux u_ss (
        .SEL_IN     (spi_slave_sel_pin_sel),
        .PINS_IN    (pin_digital),
        .ROUTED_OUT (PERIPH_IN_OUT.spi_slave_select_in)
    );
    rpsb_input_mux u_ocf (
        .SEL_IN     (compare_fault_a_pin_sel),
        .PINS_IN    (pin_digital),
        .ROUTED_OUT (PERIPH_IN_OUT.compare_fault_a)
    );

    // null function falls back to the port latch
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pin_out_func[i] == `RPSB_FUNC_NULL) begin
                REMAPPABLE_PIN_OUT[i]    = PORT_DATA_IN[i];
                REMAPPABLE_PIN_OE_OUT[i] = PORT_OE_IN[i];
            end else begin
                REMAPPABLE_PIN_OUT[i]    = PERIPH_FUNC_IN[pin_out_func[i]];
                REMAPPABLE_PIN_OE_OUT[i] =
                    PERIPH_FUNC_OE_IN[pin_out_func[i]];
            end
        end
    end

    a_lock_holds_sel: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN) io_map_lock && !(wr_en &&
        PADDR_IN == `RPSB_OFF_CTRL) |=> $stable(uart_rx_pin_sel) &&
        $stable(pin_out_func[0]))
        else $error("selector changed while locked");

    // receive field follows written low bits
    a_rx_write_low: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN) cfg_wr && PADDR_IN == `RPSB_OFF_UART_IN
        |=> uart_rx_pin_sel == $past(PWDATA_IN[4:0]))
        else $error("receive selector not written");

    // cts field follows written high bits
    a_cts_write_high: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN) cfg_wr && PADDR_IN == `RPSB_OFF_UART_IN
        |=> uart_cts_pin_sel == $past(PWDATA_IN[12:8]))
        else $error("cts selector not written");

    a_gnd_on_ones: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN) spi_din_pin_sel == 5'h1f
        |-> !PERIPH_IN_OUT.spi_data_in)
        else $error("grounded input not low");

    a_index_routes: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN) spi_clk_pin_sel < 5'h10
        |-> PERIPH_IN_OUT.spi_clock_in == pin_digital[spi_clk_pin_sel[3:0]])
        else $error("clock input misrouted");

    a_reserved_zero: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN) PREADY_OUT && !PWRITE_IN &&
        PADDR_IN != `RPSB_OFF_CTRL |-> PRDATA_OUT[31:13] == 19'h0 &&
        PRDATA_OUT[7:5] == 3'h0)
        else $error("reserved bits not zero");

    a_odd_high_field: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN) cfg_wr &&
        PADDR_IN == `RPSB_OFF_OUT_PAIR0 + 12'h004
        |=> pin_out_func[3] == $past(PWDATA_IN[12:8]) &&
        pin_out_func[2] == $past(PWDATA_IN[4:0]))
        else $error("pair 1 fields misplaced");

    a_null_port: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN) pin_out_func[5] == 5'h00
        |-> REMAPPABLE_PIN_OUT[5] == PORT_DATA_IN[5])
        else $error("null function not port data");

    // analog pin reads zero to peripherals
    a_analog_masked: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN) analog_mode[0] && uart_rx_pin_sel == 5'h00
        |-> !PERIPH_IN_OUT.uart_receive_in)
        else $error("analog pin leaked");

    a_reset_zero: assert property (@(posedge CLOCK_IN)
        $past(RESET_IN) |-> uart_rx_pin_sel == 5'h00 &&
        compare_fault_a_pin_sel == 5'h00 && pin_out_func[15] == 5'h00)
        else $error("field not cleared by reset");
endmodule

/* rtl/rpsb_defs.svh */
// register offsets, field positions and codes for the pin select bank
`ifndef RPSB_DEFS_SVH
`define RPSB_DEFS_SVH
`define RPSB_OFF_UART_IN     12'h000
`define RPSB_OFF_SPI_CD_IN   12'h004
`define RPSB_OFF_SPI_SS_IN   12'h008
`define RPSB_OFF_FAULT_IN    12'h00c
`define RPSB_OFF_OUT_PAIR0   12'h010
`define RPSB_OFF_CTRL        12'h030
`define RPSB_NUM_PAIRS       8
`define RPSB_LO_LSB          0
`define RPSB_HI_LSB          8
`define RPSB_SEL_W           5
`define RPSB_SEL_GND         5'h1f
`define RPSB_FUNC_NULL       5'h00
`define RPSB_NUM_FUNCS       32
`define RPSB_LOCK_BIT        0
`define RPSB_ANALOG_LSB      16
`define RPSB_FIELD_MASK      16'h1f1f
`define RPSB_LO_MASK         16'h001f
`endif

/* rtl/rpsb_pkg.sv */
// types shared by the pin select bank
package rpsb_pkg;
    typedef logic [4:0] rpsb_sel_t;
    typedef struct packed {
        logic uart_receive_in;
        logic uart_clear_to_send;
        logic spi_clock_in;
        logic spi_data_in;
        logic spi_slave_select_in;
        logic compare_fault_a;
    } rpsb_periph_in_t;
    typedef enum logic [1:0] {
        RPSB_IDLE   = 2'b01,
        RPSB_ACCESS = 2'b10
    } rpsb_state_t;
endpackage

/* rtl/rpsb_input_mux.sv */
// one input selector: picks a remappable pin or ground
`timescale 1ns/1ps
`include "rpsb_defs.svh"
module rpsb_input_mux (
    // select and pins
    input  wire logic [4:0]  SEL_IN,
    input  wire logic [15:0] PINS_IN,
    // routed level
    output logic             ROUTED_OUT
);
    always_comb begin
        if (SEL_IN == `RPSB_SEL_GND) begin
            ROUTED_OUT = 1'b0;
        end else if (SEL_IN[4] == 1'b0) begin
            ROUTED_OUT = PINS_IN[SEL_IN[3:0]];
        end else begin
            // codes 16..30 have no pin; treat as ground
            ROUTED_OUT = 1'b0;
        end
    end
endmodule

/* testbench/rpsb_far_model.sv */
// far side stand-in: peripheral output functions by code
`timescale 1ns/1ps
module rpsb_far_model (
    // clock
    input  wire logic        clock_in,
    // bench control
    input  wire logic        enable_in,
    input  wire logic        flip_in,
    // peripheral outputs by function code
    output logic [31:0]      func_out,
    output logic [31:0]      func_oe_out
);
    // drive output enables only when enabled; data is driven every cycle
    // mapping a pin never wakes a peripheral, so oe stays low until enabled
    always_ff @(posedge clock_in) begin
        func_out <= flip_in ? 32'h96c3_5a0f : 32'h693c_a5f0;
        if (enable_in) begin
            func_oe_out <= flip_in ? 32'h0ff0_33cc : 32'hf00f_cc33;
        end else begin
            func_oe_out <= 32'h0000_0000;
        end
    end
endmodule

/* testbench/tb_remappable_pin_select_bank.sv */
// self-checking bench for the pin select bank
`timescale 1ns/1ps
module tb_remappable_pin_select_bank;
    logic                      clock;
    logic                      reset;
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [11:0]               paddr;
    logic [31:0]               pwdata;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [15:0]               pin_in;
    logic [15:0]               pin_out;
    logic [15:0]               pin_oe;
    logic [15:0]               port_data;
    logic [15:0]               port_oe;
    logic [31:0]               func;
    logic [31:0]               func_oe;
    logic                      en;
    logic                      flip;
    rpsb_pkg::rpsb_periph_in_t periph;
    logic [5:0]                pv;
    int                        err_total;
    int                        comparisons;

    assign pv = periph;
    always #20 clock = ~clock;

    rpsb_bank rpsb_bank_i (
        .CLOCK_IN(clock), .RESET_IN(reset), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .REMAPPABLE_PIN_IN(pin_in),
        .REMAPPABLE_PIN_OUT(pin_out), .REMAPPABLE_PIN_OE_OUT(pin_oe),
        .PORT_DATA_IN(port_data), .PORT_OE_IN(port_oe),
        .PERIPH_FUNC_IN(func), .PERIPH_FUNC_OE_IN(func_oe),
        .PERIPH_IN_OUT(periph)
    );
    rpsb_far_model rpsb_far_model_i (
        .clock_in(clock), .enable_in(en), .flip_in(flip),
        .func_out(func), .func_oe_out(func_oe)
    );

    task automatic close_out();
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits on pready with no bound of its own
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // wait states are the slave's; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
    endtask

    task automatic do_reset();
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 13; i++) rd_chk(12'(4 * i), 32'h0);
        chk({16'h0, pin_out}, {16'h0, port_data});
        chk({16'h0, pin_oe}, {16'h0, port_oe});
    endtask

    // all ones to every register below control; only the five-bit fields keep them
    task automatic t_fields();
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < 12; i++) begin
            wr(12'(4 * i), 32'hffff_ffff);
            rd_chk(12'(4 * i),
                   (i == 2 || i == 3) ? 32'h1f : 32'h1f1f);
        end
        apb(1'b0, 12'h034, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
    endtask

    task automatic t_inputs();
        logic [11:0] ra[4];
        int          lo[4];
        int          hi[4];
        ra = '{12'h000, 12'h004, 12'h008, 12'h00c};
        lo = '{5, 2, 1, 0};
        hi = '{4, 3, -1, -1};
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 16; k++) begin
                wr(ra[r], {19'h0, 5'(15 - k), 3'h0, 5'(k)});
                pin_in <= 16'h1 << k;
                repeat (3) @(posedge clock);
                chk(pv[lo[r]], 1'b1);
                if (hi[r] >= 0) chk(pv[hi[r]], 1'b0);
                pin_in <= 16'h1 << (15 - k);
                repeat (3) @(posedge clock);
                chk(pv[lo[r]], 1'b0);
                if (hi[r] >= 0) chk(pv[hi[r]], 1'b1);
            end
            wr(ra[r], 32'h1f1f);
            pin_in <= 16'hffff;
            repeat (3) @(posedge clock);
            chk(pv[lo[r]], 1'b0);
            // codes with no pin behind them route ground as well
            wr(ra[r], 32'h1e10);
            @(posedge clock);
            chk(pv[lo[r]], 1'b0);
            if (hi[r] >= 0) chk(pv[hi[r]], 1'b0);
        end
        // pin 0 analog: receive on pin 0 masked, cts on pin 3 not
        wr(12'h000, 32'h0300);
        wr(12'h030, 32'h0001_0000);
        repeat (3) @(posedge clock);
        chk(pv[5], 1'b0);
        chk(pv[4], 1'b1);
        wr(12'h030, 32'h0);
        repeat (3) @(posedge clock);
        chk(pv[5], 1'b1);
    endtask

    // pass 0 codes 0..15, pass 1 codes 16..31
    task automatic t_outputs();
        logic [15:0] eo;
        logic [15:0] ee;
        int          c;
        for (int s = 0; s < 2; s++) begin
            flip <= s[0];
            en <= s[0];
            port_data <= s[0] ? 16'ha55a : 16'h3cc3;
            port_oe <= s[0] ? 16'h0ff0 : 16'hf00f;
            for (int k = 0; k < 8; k++)
                wr(12'h010 + 12'(4 * k),
                   {19'h0, 5'(2 * k + 1 + 16 * s), 3'h0, 5'(2 * k + 16 * s)});
            // last pair lands at the edge the write ends on
            @(posedge clock);
            for (int p = 0; p < 16; p++) begin
                c = p + 16 * s;
                eo[p] = (c == 0) ? port_data[p] : func[c];
                ee[p] = (c == 0) ? port_oe[p] : func_oe[c];
            end
            chk({16'h0, pin_out}, {16'h0, eo});
            chk({16'h0, pin_oe}, {16'h0, ee});
        end
        wr(12'h010, 32'h0007);
        #1;
        chk(pin_out[0], func[7]);
    endtask

    task automatic t_lock();
        wr(12'h000, 32'h0305);
        wr(12'h030, 32'h1);
        wr(12'h000, 32'h0a0b);
        wr(12'h010, 32'h0102);
        rd_chk(12'h000, 32'h0305);
        rd_chk(12'h010, 32'h0007);
        rd_chk(12'h030, 32'h1);
        wr(12'h030, 32'h0);
        wr(12'h000, 32'h0a0b);
        rd_chk(12'h000, 32'h0a0b);
    endtask

    initial begin
        #2000000;
        err_total++;
        close_out();
    end

    initial begin
        clock = 1'b0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pin_in = 16'h0000;
        port_data = 16'h3cc3;
        port_oe = 16'hf00f;
        en = 1'b0;
        flip = 1'b0;
        err_total = 0;
        comparisons = 0;
        do_reset();
        t_reset();
        t_fields();
        t_inputs();
        t_outputs();
        t_lock();
        do_reset();
        t_reset();
        close_out();
    end
endmodule
